// file: bench/dss_host.sv
`timescale 1ns/1ps
module dss_host (
    input  wire clk_i,
    output reg  sck_o,
    output reg  acc_sel_n_o,
    output reg  gyr_sel_n_o,
    output reg  mosi_o
);
    initial {sck_o, acc_sel_n_o, gyr_sel_n_o, mosi_o} = 4'hf;
    task xfer(input s, input m, input [7:0] ctl, input [7:0] wd,
              input integer nb);
        integer i;
        reg [15:0] fr;
        begin
            fr = {ctl, wd};
            sck_o <= m;
            repeat (13) @(posedge clk_i);
            {acc_sel_n_o, gyr_sel_n_o} <= {s, !s};
            for (i = 0; i < 8 + 8 * nb; i = i + 1) begin
                repeat (12) @(posedge clk_i);
                sck_o <= 1'b0;
                mosi_o <= (i < 8 || !ctl[7]) ? fr[15 - i] : !mosi_o;
                repeat (13) @(posedge clk_i);
                sck_o <= 1'b1;
            end
            repeat (12) @(posedge clk_i);
            sck_o <= m;
            repeat (13) @(posedge clk_i);
            {acc_sel_n_o, gyr_sel_n_o} <= 2'b11;
        end
    endtask
endmodule // dss_host

// file: bench/dss_port_props.sv
`timescale 1ns/1ps
module dss_port_props (
    input wire clk_i,
    input wire srst_i,
    input wire shared_serial_clock_pin_i,
    input wire accel_select_n_i,
    input wire gyro_select_n_i,
    input wire accel_serial_out_i,
    input wire shared_serial_data_pin_o,
    input wire shared_serial_data_pin_oe_o,
    input wire accel_serial_out_o,
    input wire accel_serial_out_oe_o,
    input wire gyro_serial_out_oe_o,
    input wire i2c_mode_o,
    input wire accel_addr_lsb_o,
    input wire three_wire_enable_o,
    input wire spi_mode3_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    reg  [3:0] since_fall;
    reg        sck_q;
    wire       any_sel = !accel_select_n_i || !gyro_select_n_i;
    wire       a_oe = accel_serial_out_oe_o;
    wire       w_oe = shared_serial_data_pin_oe_o;
    always @(posedge clk_i) begin
        sck_q <= shared_serial_clock_pin_i;
        if (srst_i)
            since_fall <= 4'hf;
        else if (sck_q && !shared_serial_clock_pin_i)
            since_fall <= 4'h0;
        else if (since_fall != 4'hf)
            since_fall <= since_fall + 4'h1;
    end
    chk_accel_idle: assert property (
        accel_select_n_i [*8] |-> !a_oe) else $error("accel idle drive");
    chk_gyro_idle: assert property (
        gyro_select_n_i [*8] |-> !gyro_serial_out_oe_o)
        else $error("gyro idle drive");
    chk_one_core: assert property (
        !(a_oe && gyro_serial_out_oe_o)) else $error("both cores drive");
    chk_four_wire: assert property (
        !three_wire_enable_o |-> !w_oe) else $error("shared pin driven");
    chk_three_wire: assert property (
        three_wire_enable_o |-> !a_oe && !gyro_serial_out_oe_o)
        else $error("core pin driven in 3-wire");
    chk_i2c_silent: assert property (
        i2c_mode_o |-> !(a_oe || w_oe || gyro_serial_out_oe_o))
        else $error("spi drive in i2c");
    chk_i2c_lsb: assert property (
        (i2c_mode_o && $stable(accel_serial_out_i)) [*4]
        |-> accel_addr_lsb_o == accel_serial_out_i) else $error("lsb");
    chk_data_edge: assert property (
        a_oe && $past(a_oe) && $changed(accel_serial_out_o)
        |-> since_fall >= 4'h1 && since_fall <= 4'h7)
        else $error("accel data off fall");
    chk_wire_edge: assert property (
        w_oe && $past(w_oe) && $changed(shared_serial_data_pin_o)
        |-> since_fall >= 4'h1 && since_fall <= 4'h7)
        else $error("wire data off fall");
    chk_mode_frame: assert property (
        $changed(spi_mode3_o) |-> any_sel) else $error("mode outside");
    chk_tw_frame: assert property (
        $changed(three_wire_enable_o) |-> any_sel) else $error("tw outside");
    cover property (a_oe);
    cover property (w_oe);
    cover property (i2c_mode_o);
endmodule // dss_port_props
bind dss_port dss_port_props dss_port_props_inst (
    .clk_i(clk_i), .srst_i(srst_i),
    .shared_serial_clock_pin_i(shared_serial_clock_pin_i),
    .accel_select_n_i(accel_select_n_i), .gyro_select_n_i(gyro_select_n_i),
    .accel_serial_out_i(accel_serial_out_i),
    .shared_serial_data_pin_o(shared_serial_data_pin_o),
    .shared_serial_data_pin_oe_o(shared_serial_data_pin_oe_o),
    .accel_serial_out_o(accel_serial_out_o),
    .accel_serial_out_oe_o(accel_serial_out_oe_o),
    .gyro_serial_out_oe_o(gyro_serial_out_oe_o), .i2c_mode_o(i2c_mode_o),
    .accel_addr_lsb_o(accel_addr_lsb_o),
    .three_wire_enable_o(three_wire_enable_o), .spi_mode3_o(spi_mode3_o));

// file: bench/dss_port_tb.sv
`timescale 1ns/1ps
module dss_port_tb;
    reg        clk_i = 1'b0;
    reg        srst_i = 1'b1;
    reg        strap = 1'b0;
    reg        acc_lvl = 1'b0;
    reg        gyr_lvl = 1'b0;
    wire       sck, acc_n, gyr_n, mosi, sd, sd_oe, ao, ao_oe, go, go_oe;
    wire       i2c, alsb, glsb, tw, m3;
    reg  [7:0] mem [0:255];
    reg  [7:0] expq [$];
    reg  [7:0] sh = 8'h00;
    integer    nbit = 0, errors = 0, checks = 0, cyc = 0, s, m;
    initial forever #2.5 clk_i = !clk_i;
    dss_host dss_host_inst (.clk_i(clk_i), .sck_o(sck), .acc_sel_n_o(acc_n),
        .gyr_sel_n_o(gyr_n), .mosi_o(mosi));
    dss_port dss_port_inst (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1),
        .protocol_select_strap_i(strap), .shared_serial_clock_pin_i(sck),
        .accel_select_n_i(acc_n), .gyro_select_n_i(gyr_n),
        .shared_serial_data_pin_i(sd_oe ? sd : mosi),
        .shared_serial_data_pin_o(sd), .shared_serial_data_pin_oe_o(sd_oe),
        .accel_serial_out_i(ao_oe ? ao : acc_lvl), .accel_serial_out_o(ao),
        .accel_serial_out_oe_o(ao_oe), .gyro_serial_out_i(go_oe ? go : gyr_lvl),
        .gyro_serial_out_o(go), .gyro_serial_out_oe_o(go_oe),
        .i2c_mode_o(i2c), .accel_addr_lsb_o(alsb), .gyro_addr_lsb_o(glsb),
        .three_wire_enable_o(tw), .spi_mode3_o(m3));
    task check(input [7:0] seen, input [7:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task final_report;
        begin
            $display("checks=%0d errors=%0d", checks, errors);
            if (errors == 0 && checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task wr(input integer sn, input [6:0] a, input [7:0] d);
        begin
            dss_host_inst.xfer(sn, m, {1'b0, a}, d, 1);
            mem[{sn[0], a}] = d;
            check(nbit[7:0], 8'h00);
            repeat (400) @(posedge clk_i);
        end
    endtask
    task rd(input integer sn, input [6:0] a, input integer n);
        reg [6:0] k;
        begin
            for (k = 0; k < n; k = k + 1)
                expq.push_back(mem[{sn[0], a + k}]);
            dss_host_inst.xfer(sn, m, {1'b1, a}, 8'h00, n);
            repeat (10) @(posedge clk_i);
        end
    endtask
    always @(posedge sck) begin
        if (ao_oe || go_oe || sd_oe) begin
            sh = {sh[6:0], ao_oe ? ao : go_oe ? go : sd};
            nbit = nbit + 1;
            if (nbit == 8) begin
                nbit = 0;
                check(sh, expq.pop_front());
            end
        end
    end
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc == 40000) begin
            errors = errors + 1;
            final_report;
        end
    end
    initial begin
        m = 1;
        void'($urandom(32'hb6aa7708));
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        check({5'h0, i2c, tw, m3}, 8'h00);
        for (s = 0; s < 2; s = s + 1)
            for (m = 0; m < 2; m = m + 1) begin
                wr(s, 7'h7f, $urandom);
                wr(s, 7'h00, $urandom);
                wr(s, 7'h01, $urandom);
                rd(s, 7'h7f, 3);
                check({7'h0, m3}, m[7:0]);
            end
        rd(0, 7'h00, 2);
        $display("Test four-wire burst done");
        wr(0, 7'h34, 8'h01);
        check({7'h0, tw}, 8'h00);
        wr(1, 7'h34, 8'h01);
        check({7'h0, tw}, 8'h01);
        rd(1, 7'h7f, 3);
        rd(0, 7'h00, 2);
        $display("Test three-wire done");
        strap <= 1'b1;
        {acc_lvl, gyr_lvl} <= 2'($urandom_range(3, 0));
        srst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (12) @(posedge clk_i);
        check({5'h0, i2c, alsb, glsb}, {5'h0, 1'b1, acc_lvl, gyr_lvl});
        dss_host_inst.xfer(0, 1, 8'h80, 8'h00, 1);
        check(nbit[7:0], 8'h00);
        $display("Test i2c strap done");
        final_report;
    end
endmodule // dss_port_tb

// file: design/dss_defs.vh
`ifndef DSS_DEFS_VH
`define DSS_DEFS_VH

// Control byte layout
`define DSS_DIR_READ      1'b1
`define DSS_ADDR_W        7
`define DSS_BYTE_LAST     3'h7
`define DSS_BIT_FIRST     3'h0

// Register holding the three-wire enable bit in each sensor core
`define DSS_REG_IF_CONF   7'h34
`define DSS_THREE_WIRE_ENABLE_BIT      0

// Sensor index within the register image
`define DSS_SENS_ACCEL    1'b0
`define DSS_SENS_GYRO     1'b1

// Start-up delay before the protocol strap is taken
`define DSS_STRAP_WAIT    2'h3

`endif

// file: design/dss_port.v
`timescale 1ns/1ps
`include "dss_defs.vh"
module dss_port (
    input  wire clk_i,
    input  wire srst_i,
    input  wire ce_i,
    input  wire protocol_select_strap_i,
    input  wire shared_serial_clock_pin_i,
    input  wire accel_select_n_i,
    input  wire gyro_select_n_i,
    input  wire shared_serial_data_pin_i,
    output reg  shared_serial_data_pin_o,
    output reg  shared_serial_data_pin_oe_o,
    input  wire accel_serial_out_i,
    output reg  accel_serial_out_o,
    output reg  accel_serial_out_oe_o,
    input  wire gyro_serial_out_i,
    output reg  gyro_serial_out_o,
    output reg  gyro_serial_out_oe_o,
    output reg  i2c_mode_o,
    output reg  accel_addr_lsb_o,
    output reg  gyro_addr_lsb_o,
    output reg  three_wire_enable_o,
    output reg  spi_mode3_o
);

    localparam ST_IDLE  = 5'h01;
    localparam ST_CTRL  = 5'h02;
    localparam ST_RDATA = 5'h04;
    localparam ST_WDATA = 5'h08;
    localparam ST_DONE  = 5'h10;

    // Two-stage synchronisers for all pins
    reg [1:0] sck_s;
    reg [1:0] csa_s;
    reg [1:0] csg_s;
    reg [1:0] sdx_s;
    reg [1:0] sdoa_s;
    reg [1:0] sdog_s;
    reg [1:0] strap_s;
    reg       sck_d;
    reg       cs_act_d;

    reg [4:0] state;
    reg [2:0] bit_idx;
    reg [7:0] shift_in;
    reg [7:0] shift_out;
    reg [6:0] addr;
    reg       sens;
    reg       cpol;
    reg       drive;
    reg       dout;
    reg       three_wire_enable_acc;
    reg       three_wire_enable_gyr;
    reg [1:0] strap_cnt;
    reg       strap_taken;
    reg       i2c_mode;
    reg       wr_en;
    reg [7:0] wr_data;

    wire [7:0] mem_q;
    wire [7:0] rx_byte;
    wire       sck_rise;
    wire       sck_fall;
    wire       cs_act;
    wire       three_wire;

    function sel_low;
        input s;
        input a_n;
        input g_n;
        begin
            sel_low = (s == `DSS_SENS_ACCEL) ? ~a_n : ~g_n;
        end
    endfunction

    assign sck_rise   = sck_s[1] & ~sck_d;
    assign sck_fall   = ~sck_s[1] & sck_d;
    assign cs_act     = ~csa_s[1] | ~csg_s[1];
    assign rx_byte    = {shift_in[6:0], sdx_s[1]};
    assign three_wire = three_wire_enable_acc & three_wire_enable_gyr;

    always @(posedge clk_i) begin
        if (srst_i) begin
            sck_s   <= 2'h0;
            csa_s   <= 2'h3;
            csg_s   <= 2'h3;
            sdx_s   <= 2'h0;
            sdoa_s  <= 2'h0;
            sdog_s  <= 2'h0;
            strap_s <= 2'h0;
            sck_d    <= 1'b0;
            cs_act_d <= 1'b0;
        end else if (ce_i) begin
            sck_s   <= {sck_s[0], shared_serial_clock_pin_i};
            csa_s   <= {csa_s[0], accel_select_n_i};
            csg_s   <= {csg_s[0], gyro_select_n_i};
            sdx_s   <= {sdx_s[0], shared_serial_data_pin_i};
            sdoa_s  <= {sdoa_s[0], accel_serial_out_i};
            sdog_s  <= {sdog_s[0], gyro_serial_out_i};
            strap_s <= {strap_s[0], protocol_select_strap_i};
            sck_d    <= sck_s[1];
            cs_act_d <= cs_act & ~i2c_mode;
        end
    end

    // Strap taken once after reset release
    always @(posedge clk_i) begin
        if (srst_i) begin
            strap_cnt   <= 2'h0;
            strap_taken <= 1'b0;
            i2c_mode    <= 1'b0;
        end else if (ce_i && !strap_taken) begin
            if (strap_cnt == `DSS_STRAP_WAIT) begin
                i2c_mode    <= strap_s[1];
                strap_taken <= 1'b1;
            end else begin
                strap_cnt <= strap_cnt + 2'h1;
            end
        end
    end

    // Serial engine
    always @(posedge clk_i) begin
        if (srst_i) begin
            state     <= ST_IDLE;
            bit_idx   <= `DSS_BIT_FIRST;
            shift_in  <= 8'h00;
            shift_out <= 8'h00;
            addr      <= 7'h00;
            sens      <= `DSS_SENS_ACCEL;
            cpol      <= 1'b0;
            drive     <= 1'b0;
            dout      <= 1'b0;
            three_wire_enable_acc  <= 1'b0;
            three_wire_enable_gyr  <= 1'b0;
            wr_en     <= 1'b0;
            wr_data   <= 8'h00;
        end else if (ce_i) begin
            wr_en <= 1'b0;
            if (state != ST_IDLE &&
                !sel_low(sens, csa_s[1], csg_s[1])) begin
                state <= ST_IDLE;
                drive <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        drive <= 1'b0;
                        if (strap_taken && !i2c_mode && cs_act &&
                            !cs_act_d) begin
                            state   <= ST_CTRL;
                            bit_idx <= `DSS_BIT_FIRST;
                            cpol    <= sck_s[1];
                            sens    <= csa_s[1] ? `DSS_SENS_GYRO
                                                : `DSS_SENS_ACCEL;
                        end
                    end
                    ST_CTRL: begin
                        if (sck_rise) begin
                            shift_in <= rx_byte;
                            bit_idx  <= bit_idx + 3'h1;
                            if (bit_idx == `DSS_BYTE_LAST) begin
                                addr <= rx_byte[6:0];
                                if (shift_in[6] == `DSS_DIR_READ) begin
                                    state <= ST_RDATA;
                                end else begin
                                    state <= ST_WDATA;
                                end
                            end
                        end
                    end
                    ST_RDATA: begin
                        if (sck_fall) begin
                            drive <= 1'b1;
                            if (bit_idx == `DSS_BIT_FIRST) begin
                                dout      <= mem_q[7];
                                shift_out <= {mem_q[6:0], 1'b0};
                                addr      <= addr + 7'h01;
                            end else begin
                                dout      <= shift_out[7];
                                shift_out <= {shift_out[6:0], 1'b0};
                            end
                        end
                        if (sck_rise) begin
                            bit_idx <= bit_idx + 3'h1;
                        end
                    end
                    ST_WDATA: begin
                        drive <= 1'b0;
                        if (sck_rise) begin
                            shift_in <= rx_byte;
                            bit_idx  <= bit_idx + 3'h1;
                            if (bit_idx == `DSS_BYTE_LAST) begin
                                wr_en   <= 1'b1;
                                wr_data <= rx_byte;
                                state   <= ST_DONE;
                                if (addr == `DSS_REG_IF_CONF) begin
                                    if (sens == `DSS_SENS_ACCEL) begin
                                        three_wire_enable_acc <=
                                            rx_byte[`DSS_THREE_WIRE_ENABLE_BIT];
                                    end else begin
                                        three_wire_enable_gyr <=
                                            rx_byte[`DSS_THREE_WIRE_ENABLE_BIT];
                                    end
                                end
                            end
                        end
                    end
                    ST_DONE: begin
                        drive <= 1'b0;
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Pin drivers, all registered
    always @(posedge clk_i) begin
        if (srst_i) begin
            shared_serial_data_pin_o    <= 1'b0;
            shared_serial_data_pin_oe_o <= 1'b0;
            accel_serial_out_o          <= 1'b0;
            accel_serial_out_oe_o       <= 1'b0;
            gyro_serial_out_o           <= 1'b0;
            gyro_serial_out_oe_o        <= 1'b0;
            i2c_mode_o                  <= 1'b0;
            accel_addr_lsb_o            <= 1'b0;
            gyro_addr_lsb_o             <= 1'b0;
            three_wire_enable_o         <= 1'b0;
            spi_mode3_o                 <= 1'b0;
        end else if (ce_i) begin
            shared_serial_data_pin_o    <= dout;
            shared_serial_data_pin_oe_o <= drive & three_wire;
            accel_serial_out_o          <= dout;
            accel_serial_out_oe_o       <= drive & ~three_wire &
                                           (sens == `DSS_SENS_ACCEL);
            gyro_serial_out_o           <= dout;
            gyro_serial_out_oe_o        <= drive & ~three_wire &
                                           (sens == `DSS_SENS_GYRO);
            i2c_mode_o                  <= i2c_mode;
            if (i2c_mode) begin
                accel_addr_lsb_o <= sdoa_s[1];
                gyro_addr_lsb_o  <= sdog_s[1];
            end
            three_wire_enable_o <= three_wire;
            spi_mode3_o         <= cpol;
        end
    end

    dss_regmem #(
        .AW (8),
        .DW (8)
    ) u_regmem (
        .clk_i   (clk_i),
        .ce_i    (ce_i),
        .we_i    (wr_en),
        .waddr_i ({sens, addr}),
        .wdata_i (wr_data),
        .raddr_i ({sens, addr}),
        .rdata_o (mem_q)
    );

endmodule // dss_port

// file: design/dss_regmem.v
`timescale 1ns/1ps
module dss_regmem #(
    parameter AW = 8,
    parameter DW = 8
) (
    input  wire          clk_i,
    input  wire          ce_i,
    input  wire          we_i,
    input  wire [AW-1:0] waddr_i,
    input  wire [DW-1:0] wdata_i,
    input  wire [AW-1:0] raddr_i,
    output reg  [DW-1:0] rdata_o
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Register image, read data registered
    always @(posedge clk_i) begin
        if (ce_i) begin
            if (we_i) begin
                mem[waddr_i] <= wdata_i;
            end
            rdata_o <= mem[raddr_i];
        end
    end

endmodule // dss_regmem
